// ===== cpm_controller.sv
// Power-mode controller with extended interrupt priority registers.
// Assumes the core gives a strobe at the end of each instruction, and
// that interrupt requests and reset causes are already on mclk.
`timescale 1ns/100ps
module cpm_controller #(
  parameter int NSRC = cpm_pkg::NUM_EXT_SOURCES
) (
  input  wire logic            mclk,          // System clock
  input  wire logic            rst,           // Synchronous reset
  input  wire logic            ce,            // Clock enable
  input  wire logic            wrEn,          // Register write strobe
  input  wire logic            rdEn,          // Register read strobe
  input  wire logic [7:0]      addr,          // Register address
  input  wire logic [7:0]      wrData,        // Write data
  input  wire logic            instrDone,     // Current instruction ends
  input  wire logic            irqEnabled,    // Some enabled irq pending
  input  wire logic [NSRC-1:0] extIrqReq,     // Enabled extended requests
  input  wire logic            irqReturn,     // Return from interrupt
  input  wire logic            resetPin,      // External reset, synced
  input  wire logic            watchdogReset, // Watchdog overflow reset
  input  wire logic            clockLostReset,// Missing clock reset
  output logic [7:0]           rdData,        // Register read data
  output logic                 cpuClockGate,  // High stops the core clock
  output logic                 oscStop,       // High stops oscillators
  output logic                 periphHalt,    // Digital peripherals halted
  output logic                 coreRestart,   // Restart at reset address
  output logic                 irqTake,       // Grant an interrupt now
  output logic                 irqTakeHigh,   // Granted irq is high level
  output logic [1:0]           mode           // Current power mode
);
  logic [7:0] prio1;
  logic [7:0] prio2;
  cpm_pkg::cpm_mode_t state;
  cpm_pkg::cpm_mode_t next_state;
  logic idlePending;
  logic stopPending;
  logic inHighService;
  logic inLowService;

  cpm_prio_reg #(.ADDR(cpm_pkg::ADDR_EXT_PRIO_1)) uPrio1 (
    .mclk   (mclk),
    .rst    (rst),
    .ce     (ce),
    .wrEn   (wrEn),
    .addr   (addr),
    .wrData (wrData),
    .value  (prio1)
  );
  cpm_prio_reg #(.ADDR(cpm_pkg::ADDR_EXT_PRIO_2)) uPrio2 (
    .mclk   (mclk),
    .rst    (rst),
    .ce     (ce),
    .wrEn   (wrEn),
    .addr   (addr),
    .wrData (wrData),
    .value  (prio2)
  );

  wire [15:0] prioAll  = {prio2, prio1};
  wire        powerCtlHit = wrEn && (addr == cpm_pkg::ADDR_POWER_CONTROL);
  wire        idleWr   = powerCtlHit && wrData[cpm_pkg::BIT_IDLE_SELECT];
  wire        stopWr   = powerCtlHit && wrData[cpm_pkg::BIT_STOP_SELECT];
  // Any reset cause; the clock checker stays armed even in stop
  wire        anyReset = resetPin || watchdogReset || clockLostReset;
  wire [NSRC-1:0] hiReq = extIrqReq & prioAll[NSRC-1:0];
  wire [NSRC-1:0] loReq = extIrqReq & ~prioAll[NSRC-1:0];
  wire        hiAny    = |hiReq;
  wire        loAny    = |loReq;
  // High level preempts low service; nothing preempts high service
  wire        grantHi  = hiAny && !inHighService;
  wire        grantLo  = !hiAny && loAny && !inHighService
                         && !inLowService;
  wire        runState = (state == cpm_pkg::CPM_RUN);
  wire        grantNow = runState && (grantHi || grantLo);
  // Mode bits read zero regardless of writes
  wire [7:0]  rdMux =
    (addr == cpm_pkg::ADDR_EXT_PRIO_1)    ? prio1 :
    (addr == cpm_pkg::ADDR_EXT_PRIO_2)    ? prio2 :
    8'h00;

  always_comb begin
    next_state = state;
    case (state)
      cpm_pkg::CPM_RUN: begin
        if (instrDone && stopPending) begin
          next_state = cpm_pkg::CPM_STOP;
        end else if (instrDone && idlePending) begin
          next_state = cpm_pkg::CPM_IDLE;
        end
      end
      cpm_pkg::CPM_IDLE: begin
        if (irqEnabled) begin
          next_state = cpm_pkg::CPM_RUN;
        end
      end
      cpm_pkg::CPM_STOP: begin
        next_state = cpm_pkg::CPM_STOP;
      end
      default: begin
        next_state = cpm_pkg::CPM_RUN;
      end
    endcase
  end

  // Any reset cause overrides the mode and restarts the core
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= cpm_pkg::CPM_RUN;
    end else if (ce) begin
      if (anyReset) begin
        state <= cpm_pkg::CPM_RUN;
      end else begin
        state <= next_state;
      end
    end
  end

  // Select bits wait for the writing instruction to complete
  always_ff @(posedge mclk) begin
    if (rst) begin
      idlePending <= cpm_pkg::RESET_POWER_CONTROL[cpm_pkg::BIT_IDLE_SELECT];
      stopPending <= cpm_pkg::RESET_POWER_CONTROL[cpm_pkg::BIT_STOP_SELECT];
    end else if (ce) begin
      if (anyReset || (runState && instrDone)) begin
        idlePending <= 1'b0;
        stopPending <= 1'b0;
      end else begin
        idlePending <= idlePending || idleWr;
        stopPending <= stopPending || stopWr;
      end
    end
  end

  // Service level tracking for nesting, up to one level of each
  always_ff @(posedge mclk) begin
    if (rst || (ce && anyReset)) begin
      inHighService <= 1'b0;
      inLowService  <= 1'b0;
    end else if (ce) begin
      if (grantNow && grantHi) begin
        inHighService <= 1'b1;
      end else if (grantNow && grantLo) begin
        inLowService <= 1'b1;
      end else if (irqReturn && inHighService) begin
        inHighService <= 1'b0;
      end else if (irqReturn) begin
        inLowService <= 1'b0;
      end
    end
  end

  // Outputs registered; peripherals keep running in idle
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdData       <= 8'h00;
      cpuClockGate <= 1'b0;
      oscStop      <= 1'b0;
      periphHalt   <= 1'b0;
      coreRestart  <= 1'b0;
      irqTake      <= 1'b0;
      irqTakeHigh  <= 1'b0;
      mode         <= cpm_pkg::CPM_RUN;
    end else if (ce) begin
      rdData       <= rdEn ? rdMux : 8'h00;
      cpuClockGate <= !anyReset
                      && (next_state != cpm_pkg::CPM_RUN);
      oscStop      <= !anyReset
                      && (next_state == cpm_pkg::CPM_STOP);
      periphHalt   <= !anyReset
                      && (next_state == cpm_pkg::CPM_STOP);
      coreRestart  <= anyReset;
      irqTake      <= grantNow && !anyReset;
      irqTakeHigh  <= grantNow && grantHi && !anyReset;
      mode         <= anyReset ? cpm_pkg::CPM_RUN : next_state;
    end
  end

  AST_IDLE_ENTRY: assert property (@(posedge mclk) disable iff (rst)
    ce && runState && instrDone && idlePending && !stopPending
    && !anyReset |=> state == cpm_pkg::CPM_IDLE)
    else $error("idle not entered");
  AST_IDLE_WAKE: assert property (@(posedge mclk) disable iff (rst)
    ce && state == cpm_pkg::CPM_IDLE && irqEnabled
    |=> state == cpm_pkg::CPM_RUN)
    else $error("idle not left on interrupt");
  AST_STOP_ENTRY: assert property (@(posedge mclk) disable iff (rst)
    ce && runState && instrDone && stopPending && !anyReset
    |=> state == cpm_pkg::CPM_STOP ##1 oscStop || !ce)
    else $error("stop not entered");
  AST_STOP_HOLD: assert property (@(posedge mclk) disable iff (rst)
    state == cpm_pkg::CPM_STOP && !anyReset
    |=> state == cpm_pkg::CPM_STOP)
    else $error("stop left without reset");
  AST_RESET_EXIT: assert property (@(posedge mclk) disable iff (rst)
    ce && anyReset |=> state == cpm_pkg::CPM_RUN && coreRestart)
    else $error("reset did not restart core");
  AST_MODE_READ_ZERO: assert property (@(posedge mclk) disable iff (rst)
    ce && rdEn && addr == cpm_pkg::ADDR_POWER_CONTROL
    |=> rdData == 8'h00)
    else $error("power control read not zero");
  AST_PRIO_READBACK: assert property (@(posedge mclk) disable iff (rst)
    ce && wrEn && addr == cpm_pkg::ADDR_EXT_PRIO_1
    ##1 ce && rdEn && !wrEn && addr == cpm_pkg::ADDR_EXT_PRIO_1
    |=> rdData == $past(wrData, 2))
    else $error("priority 1 readback wrong");
  AST_NO_LOW_PREEMPT: assert property (@(posedge mclk) disable iff (rst)
    inHighService |-> !(grantNow && grantLo))
    else $error("low preempted high service");
  AST_IDLE_PERIPH: assert property (@(posedge mclk) disable iff (rst)
    state == cpm_pkg::CPM_IDLE |-> !periphHalt && !oscStop)
    else $error("peripherals halted in idle");

  // Second register readback, mirrors the first
  AST_PRIO2_READBACK: assert property (@(posedge mclk) disable iff (rst)
    ce && wrEn && addr == cpm_pkg::ADDR_EXT_PRIO_2
    ##1 ce && rdEn && !wrEn && addr == cpm_pkg::ADDR_EXT_PRIO_2
    |=> rdData == $past(wrData, 2))
    else $error("priority 2 readback wrong");

  // Priority grants; only one nesting level of each kind is tracked
  AST_HIGH_PREEMPT: assert property (@(posedge mclk) disable iff (rst)
    ce && runState && inLowService && !inHighService && hiAny
    && !anyReset |=> irqTake && irqTakeHigh)
    else $error("high request did not preempt low service");
  AST_LOW_GRANT: assert property (@(posedge mclk) disable iff (rst)
    ce && runState && !inHighService && !inLowService && !hiAny
    && loAny && !anyReset |=> irqTake && !irqTakeHigh)
    else $error("low request not granted at low level");
  AST_NO_GRANT_ASLEEP: assert property (@(posedge mclk) disable iff (rst)
    ce && !runState |=> !irqTake)
    else $error("interrupt granted while halted");

  // Registered outputs follow the state; they lag nothing since both
  // are loaded from next_state on the same edge
  AST_IDLE_GATE: assert property (@(posedge mclk) disable iff (rst)
    state == cpm_pkg::CPM_IDLE |-> cpuClockGate)
    else $error("core clock not gated in idle");
  AST_IDLE_MODE_OUT: assert property (@(posedge mclk) disable iff (rst)
    state == cpm_pkg::CPM_IDLE |-> mode == cpm_pkg::CPM_IDLE)
    else $error("mode output not idle");
  AST_STOP_OSC: assert property (@(posedge mclk) disable iff (rst)
    state == cpm_pkg::CPM_STOP |-> oscStop && periphHalt)
    else $error("oscillators not stopped in stop");
  AST_STOP_MODE_OUT: assert property (@(posedge mclk) disable iff (rst)
    state == cpm_pkg::CPM_STOP |-> mode == cpm_pkg::CPM_STOP)
    else $error("mode output not stop");
  AST_IDLE_KEEPS_REGS: assert property (@(posedge mclk) disable iff (rst)
    state == cpm_pkg::CPM_IDLE && !wrEn
    |=> $stable(prio1) && $stable(prio2))
    else $error("priority registers changed in idle");

  // Wake and restart paths
  AST_IDLE_BIT_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    ce && state == cpm_pkg::CPM_IDLE && irqEnabled && !wrEn
    |=> !idlePending)
    else $error("idle select left set after wake");
  AST_PIN_IDLE_EXIT: assert property (@(posedge mclk) disable iff (rst)
    ce && state == cpm_pkg::CPM_IDLE && resetPin
    |=> mode == cpm_pkg::CPM_RUN && coreRestart)
    else $error("reset pin did not end idle");
  AST_WATCHDOG_IDLE_EXIT: assert property (@(posedge mclk)
    disable iff (rst) ce && state == cpm_pkg::CPM_IDLE && watchdogReset
    |=> state == cpm_pkg::CPM_RUN && coreRestart)
    else $error("watchdog did not end idle");
  AST_CLOCK_LOST_EXIT: assert property (@(posedge mclk) disable iff (rst)
    ce && state == cpm_pkg::CPM_STOP && clockLostReset
    |=> state == cpm_pkg::CPM_RUN && !oscStop)
    else $error("clock checker did not end stop");
  AST_RESTART_ONLY_RESET: assert property (@(posedge mclk)
    disable iff (rst) ce && !anyReset |=> !coreRestart)
    else $error("restart without reset cause");

  COV_IDLE_WAKE: cover property (@(posedge mclk)
    state == cpm_pkg::CPM_IDLE ##1 state == cpm_pkg::CPM_RUN);
  COV_STOP_RESET: cover property (@(posedge mclk)
    state == cpm_pkg::CPM_STOP ##1 coreRestart);
  COV_PREEMPT: cover property (@(posedge mclk)
    inLowService && grantNow && grantHi);
  COV_HIGH_GRANT: cover property (@(posedge mclk)
    irqTake && irqTakeHigh);
  COV_IDLE_WATCHDOG: cover property (@(posedge mclk)
    state == cpm_pkg::CPM_IDLE && watchdogReset);
endmodule

// ===== cpm_pkg.sv
// Package for the core power-mode and extended priority controller.
// Assumes an 8-bit special-function-register bus driven by the core.
package cpm_pkg;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_EXT_PRIO_1    = 8'hF6;
  localparam logic [7:0] ADDR_EXT_PRIO_2    = 8'hF7;
  localparam logic [7:0] RESET_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RESET_EXT_PRIO      = 8'h00;
  localparam int         BIT_IDLE_SELECT     = 0;
  localparam int         BIT_STOP_SELECT     = 1;
  localparam logic [15:0] RESET_ADDRESS      = 16'h0000;
  localparam int         CLOCK_CHECK_TIMEOUT_US     = 100;
  localparam int         CLOCK_MHZ                  = 200;
  localparam int         CLOCK_CHECK_TIMEOUT_CYCLES =
    CLOCK_CHECK_TIMEOUT_US * CLOCK_MHZ;
  localparam int         NUM_EXT_SOURCES     = 16;

  typedef enum logic [1:0] {
    CPM_RUN  = 2'b00,
    CPM_IDLE = 2'b01,
    CPM_STOP = 2'b10
  } cpm_mode_t;
endpackage

// ===== cpm_prio_reg.sv
// One 8-bit read/write priority register on the register bus.
// Assumes single-cycle write strobes from the core.
`timescale 1ns/100ps
module cpm_prio_reg #(
  parameter logic [7:0] ADDR = 8'h00
) (
  input  wire logic       mclk,    // System clock
  input  wire logic       rst,     // Synchronous reset
  input  wire logic       ce,      // Clock enable
  input  wire logic       wrEn,    // Register write strobe
  input  wire logic [7:0] addr,    // Register address
  input  wire logic [7:0] wrData,  // Write data
  output logic      [7:0] value    // Stored priority bits
);
  wire hit = wrEn && (addr == ADDR);

  always_ff @(posedge mclk) begin
    if (rst) begin
      value <= cpm_pkg::RESET_EXT_PRIO;
    end else if (ce && hit) begin
      value <= wrData;
    end
  end
endmodule

// ===== cpm_core_model.sv
// Behavioural stand-in for the core's instruction sequencer.
// Assumes the bench raises issue for one cycle per instruction end wanted.
`timescale 1ns/100ps
module cpm_core_model (
  input  wire logic mclk,      // System clock
  input  wire logic rst,       // Synchronous reset
  input  wire logic issue,     // Bench asks for an instruction end
  input  wire logic slow,      // Add one cycle before the end
  output logic      instrDone  // Instruction-end pulse
);
  logic delayed;
  // The mode write is taken as a multi-byte opcode, so no irq splits it
  always_ff @(posedge mclk) begin
    if (rst) begin
      delayed   <= 1'b0;
      instrDone <= 1'b0;
    end else begin
      delayed   <= issue & slow;
      instrDone <= (issue & ~slow) | delayed;
    end
  end
endmodule

// ===== cpm_controller_tb_top.sv
// Self-checking bench for the power-mode and priority controller.
// Assumes the core model supplies instruction ends; runs on a 5 ns clock.
`timescale 1ns/100ps
module cpm_controller_tb_top;
  logic       mclk = 1'b0, rst = 1'b1, wrEn = 1'b0, rdEn = 1'b0;
  logic       irqEnabled = 1'b0, issue = 1'b0, slow = 1'b0, instrDone;
  logic [2:0] cause = 3'h0;
  logic [7:0] addr = 8'h00, wrData = 8'h00, rdData;
  logic       cpuClockGate, oscStop, periphHalt, coreRestart;
  logic [1:0] mode;
  logic       ce = 1'b1, irqRet = 1'b0, irqTake, irqTakeHigh;
  logic [15:0] extIrq = 16'h0000;
  int         n_mismatch = 0, compares = 0, cyc = 0;

  always #2.5 mclk = ~mclk;
  // Ceiling well above the roughly 110 cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      end_sim();
    end
  end

  cpm_core_model core_u (.mclk(mclk), .rst(rst), .issue(issue),
    .slow(slow), .instrDone(instrDone));
  cpm_controller #(.NSRC(16)) dut_u (.mclk(mclk), .rst(rst), .ce(ce),
    .wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wrData(wrData),
    .instrDone(instrDone), .irqEnabled(irqEnabled),
    .extIrqReq(extIrq), .irqReturn(irqRet), .resetPin(cause[0]),
    .watchdogReset(cause[1]), .clockLostReset(cause[2]), .rdData(rdData),
    .cpuClockGate(cpuClockGate), .oscStop(oscStop),
    .periphHalt(periphHalt), .coreRestart(coreRestart), .irqTake(irqTake),
    .irqTakeHigh(irqTakeHigh), .mode(mode));

  task step();
    @(posedge mclk);
    #1;
  endtask
  task chk(string nm, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    wrEn = 1'b1; addr = a; wrData = d;
    step();
    wrEn = 1'b0;
    step();
  endtask
  task rd(logic [7:0] a, logic [7:0] exp, string nm);
    rdEn = 1'b1; addr = a;
    step();
    rdEn = 1'b0;
    chk(nm, exp, rdData);
    step();
  endtask
  // Write then read the same register on the very next cycle
  task wrRd(logic [7:0] a, logic [7:0] d, string nm);
    wrEn = 1'b1; addr = a; wrData = d;
    step();
    wrEn = 1'b0;
    rdEn = 1'b1;
    step();
    rdEn = 1'b0;
    chk(nm, d, rdData);
    step();
  endtask
  task endInstr(logic sl);
    slow = sl; issue = 1'b1;
    step();
    issue = 1'b0;
  endtask
  task waitMode(logic [1:0] m);
    for (int i = 0; i < 20 && mode !== m; i++) step();
    chk("mode", {6'h00, m}, {6'h00, mode});
  endtask
  task waitRestart();
    for (int i = 0; i < 8 && coreRestart !== 1'b1; i++) step();
    chk("coreRestart", 8'h01, {7'h00, coreRestart});
  endtask
  task pulseCause(logic [2:0] c);
    cause = c;
    step();
    cause = 3'h0;
  endtask

  task tRegs();
    rd(8'hF6, 8'h00, "prio1 reset");
    rd(8'hF7, 8'h00, "prio2 reset");
    rd(8'h87, 8'h00, "power reset");
    wrRd(8'hF6, 8'hA5, "prio1 now");
    wrRd(8'hF7, 8'h5A, "prio2 now");
    wr(8'h87, 8'hFC);
    wr(8'h88, 8'hFF);
    rd(8'hF6, 8'hA5, "prio1");
    rd(8'hF7, 8'h5A, "prio2");
    rd(8'h87, 8'h00, "power reserved");
    $display("test regs done");
  endtask
  // Source 0 is high, 1 low (first register); source 9 high (second)
  task tPrio();
    extIrq = 16'h0002;
    step();
    chk("low take", 8'h02, {6'h00, irqTake, irqTakeHigh});
    extIrq = 16'h0003;
    step();
    chk("high preempt", 8'h03, {6'h00, irqTake, irqTakeHigh});
    extIrq = 16'h0002;
    step();
    chk("low blocked", 8'h00, {6'h00, irqTake, irqTakeHigh});
    irqRet = 1'b1;
    step();
    irqRet = 1'b0;
    step();
    irqRet = 1'b1;
    step();
    irqRet = 1'b0;
    extIrq = 16'h0200;
    step();
    chk("prio2 high", 8'h03, {6'h00, irqTake, irqTakeHigh});
    irqRet = 1'b1;
    extIrq = 16'h0000;
    step();
    irqRet = 1'b0;
    ce = 1'b0;
    wr(8'hF6, 8'h00);
    ce = 1'b1;
    rd(8'hF6, 8'hA5, "prio1 frozen");
    $display("test prio done");
  endtask
  task tIdle();
    wr(8'h87, 8'h01);
    step();
    chk("mode before end", 8'h00, {6'h00, mode});
    endInstr(1'b0);
    waitMode(cpm_pkg::CPM_IDLE);
    chk("gate", 8'h01, {7'h00, cpuClockGate});
    chk("periph idle", 8'h00, {6'h00, oscStop, periphHalt});
    rd(8'hF6, 8'hA5, "prio1 idle");
    irqEnabled = 1'b1;
    waitMode(cpm_pkg::CPM_RUN);
    irqEnabled = 1'b0;
    rd(8'h87, 8'h00, "idle bit");
    $display("test idle done");
  endtask
  // Each reset cause in turn must end stop; irqs alone never may
  task tStop(int c);
    wr(8'h87, 8'h02);
    endInstr(1'b1);
    waitMode(cpm_pkg::CPM_STOP);
    chk("stop halt", 8'h03, {6'h00, oscStop, periphHalt});
    irqEnabled = 1'b1;
    repeat (8) step();
    chk("stop irq", 8'h02, {6'h00, mode});
    irqEnabled = 1'b0;
    pulseCause(3'h1 << c);
    waitRestart();
    waitMode(cpm_pkg::CPM_RUN);
    $display("test stop cause %0d done", c);
  endtask
  task tIdleWatchdog();
    wr(8'h87, 8'h01);
    endInstr(1'b0);
    waitMode(cpm_pkg::CPM_IDLE);
    pulseCause(3'h2);
    waitRestart();
    waitMode(cpm_pkg::CPM_RUN);
    $display("test idle watchdog done");
  endtask

  task end_sim();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20) step();
    rst = 1'b0;
    tRegs();
    tPrio();
    tIdle();
    for (int c = 0; c < 3; c++) tStop(c);
    tIdleWatchdog();
    end_sim();
  end
endmodule
